/* File: psid_lane.sv */
/*
 * Package of shared constants for the packed SIMD integer datapath, and the
 * single-lane add/subtract cell that applies the wraparound or saturation policy.
 * Assumes the cell is purely combinational and sits inside a clocked datapath.
 */
`timescale 1ns/1ps

package psid_pkg;
	localparam int PSID_NREGS = 8;
	localparam int PSID_IDX_W = 3;
	localparam int PSID_DATA_W = 64;
	localparam int PSID_HALF_W = 32;
	localparam int PSID_BYTE_W = 8;
	localparam int PSID_WORD_W = 16;
	localparam int PSID_DWORD_W = 32;
	localparam int PSID_NBYTES = 8;
	localparam int PSID_NWORDS = 4;
	localparam int PSID_NDWORDS = 2;
	// Saturation limits
	localparam logic [7:0] PSID_SB_MIN = 8'h80;
	localparam logic [7:0] PSID_SB_MAX = 8'h7F;
	localparam logic [7:0] PSID_UB_MIN = 8'h00;
	localparam logic [7:0] PSID_UB_MAX = 8'hFF;
	localparam logic [15:0] PSID_SW_MIN = 16'h8000;
	localparam logic [15:0] PSID_SW_MAX = 16'h7FFF;
	localparam logic [15:0] PSID_UW_MIN = 16'h0000;
	localparam logic [15:0] PSID_UW_MAX = 16'hFFFF;
	// Doubleword lanes never saturate; these limits are never selected
	localparam logic [31:0] PSID_SD_MIN = 32'h8000_0000;
	localparam logic [31:0] PSID_SD_MAX = 32'h7FFF_FFFF;
	localparam logic [31:0] PSID_UD_MIN = 32'h0000_0000;
	localparam logic [31:0] PSID_UD_MAX = 32'hFFFF_FFFF;
	localparam logic [7:0] PSID_BE_FULL = 8'hFF;
	localparam logic [7:0] PSID_BE_LOW = 8'h0F;

	typedef enum logic [3:0] {
		PSID_OP_NOP = 4'h0,
		PSID_OP_ADD = 4'h1,
		PSID_OP_SUB = 4'h2,
		PSID_OP_AND = 4'h3,
		PSID_OP_ANDN = 4'h4,
		PSID_OP_OR = 4'h5,
		PSID_OP_XOR = 4'h6,
		PSID_OP_MOVQ_RR = 4'h7,
		PSID_OP_LOAD64 = 4'h8,
		PSID_OP_LOAD32 = 4'h9,
		PSID_OP_STORE64 = 4'hA,
		PSID_OP_STORE32 = 4'hB,
		PSID_OP_FROM_GP = 4'hC,
		PSID_OP_TO_GP = 4'hD,
		PSID_OP_UNPK_LO = 4'hE,
		PSID_OP_UNPK_HI = 4'hF
	} psid_op_t;

	typedef enum logic [1:0] {
		PSID_SZ_B = 2'h0,
		PSID_SZ_W = 2'h1,
		PSID_SZ_D = 2'h2
	} psid_size_t;

	typedef enum logic [1:0] {
		PSID_MODE_WRAP = 2'h0,
		PSID_MODE_SSAT = 2'h1,
		PSID_MODE_USAT = 2'h2
	} psid_mode_t;
endpackage

module psid_lane #(
	parameter int W = 8,
	parameter logic [W-1:0] SMIN = '0,
	parameter logic [W-1:0] SMAX = '0,
	parameter logic [W-1:0] UMIN = '0,
	parameter logic [W-1:0] UMAX = '0
) (
	input wire logic [W-1:0] a,
	input wire logic [W-1:0] b,
	input wire logic sub,
	input wire psid_pkg::psid_mode_t mode,
	output logic [W-1:0] y
);
	logic [W+1:0] ssum;
	logic [W+1:0] usum;
	logic s_ovf;

	// Two guard bits keep the true result of this lane only
	always_comb begin
		if (sub) begin
			ssum = {a[W-1], a[W-1], a} - {b[W-1], b[W-1], b};
			usum = {2'b00, a} - {2'b00, b};
		end else begin
			ssum = {a[W-1], a[W-1], a} + {b[W-1], b[W-1], b};
			usum = {2'b00, a} + {2'b00, b};
		end
		s_ovf = (ssum[W+1] != ssum[W-1]);
		y = ssum[W-1:0];
		case (mode)
			psid_pkg::PSID_MODE_SSAT: begin
				if (s_ovf) begin
					y = ssum[W+1] ? SMIN : SMAX;
				end
			end
			psid_pkg::PSID_MODE_USAT: begin
				if (usum[W+1]) begin
					y = UMIN;
				end else if (usum[W]) begin
					y = UMAX;
				end
			end
			default: begin
			end
		endcase
	end
endmodule

/* File: psid_datapath.sv */
/*
 * Packed SIMD integer datapath: eight 64-bit packed registers shared with the
 * floating-point data stack, lane-wise arithmetic and logic, moves and unpacks.
 * Assumes issue and load/store logic present one operation per cycle, in step
 * with clk, and that the floating-point unit reaches the same storage here.
 */
// Summary of operation
// - Eight 64-bit packed registers for operands, results
// - Register bits equal memory quadword bits exactly
// - Full 64-bit access for quad moves, arithmetic
// - 32-bit access for doubleword moves, some unpacks
// - Packed registers alias floating-point stack slots
// - Registers viewed as bytes, words or doublewords
// - Quad moves carry whole 64-bit block unchanged
// - Same operation applied to every lane together
// - Memory layout little endian, low byte first
// - Wraparound keeps only low lane bits
// - Signed word saturation clamps to word limits
// - Signed byte saturation clamps to byte limits
// - Unsigned byte saturation gives all-ones or zero
// - Unsigned word saturation clamps zero to all-ones
// - No exceptions, no condition flag updates
// - Signed saturating word add writes four words
// - Registers indexed zero through seven
// - Saturation for bytes, words; wrap for all
`timescale 1ns/1ps

module psid_datapath (
	input wire logic clk,
	input wire logic resetn,
	input wire logic op_valid,
	input wire psid_pkg::psid_op_t op_code,
	input wire psid_pkg::psid_size_t op_size,
	input wire psid_pkg::psid_mode_t op_mode,
	input wire logic [2:0] op_dst,
	input wire logic [2:0] op_src,
	input wire logic [63:0] mem_rdata,
	input wire logic [31:0] gp_wdata,
	input wire logic fpu_wr_en,
	input wire logic [2:0] fpu_wr_idx,
	input wire logic [63:0] fpu_wr_data,
	input wire logic [2:0] fpu_rd_idx,
	output logic res_valid_r,
	output logic [63:0] res_data_r,
	output logic mem_wvalid_r,
	output logic [63:0] mem_wdata_r,
	output logic [7:0] mem_wbe_r,
	output logic gp_rvalid_r,
	output logic [31:0] gp_rdata_r,
	output logic [63:0] fpu_rd_data_r,
	output logic condition_flag_register_we_r,
	output logic exception_r
);
	localparam int NB = psid_pkg::PSID_NBYTES;
	localparam int NW = psid_pkg::PSID_NWORDS;
	localparam int ND = psid_pkg::PSID_NDWORDS;
	localparam int BW = psid_pkg::PSID_BYTE_W;
	localparam int WW = psid_pkg::PSID_WORD_W;
	localparam int DW = psid_pkg::PSID_DWORD_W;
	localparam int HW = psid_pkg::PSID_HALF_W;

	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	// Index 0 is packed_reg_first / fpu_stack_slot_first, 7 the last
	logic [63:0] regs_r [psid_pkg::PSID_NREGS];
	logic [63:0] dst_val;
	logic [63:0] src_val;
	logic [63:0] wr_data;
	logic wr_en;

	assign dst_val = regs_r[op_dst];
	assign src_val = regs_r[op_src];

	// ------------------------------------------------------------
	// Lane arithmetic
	// ------------------------------------------------------------
	logic [63:0] sum_b;
	logic [63:0] sum_w;
	logic [63:0] sum_d;
	logic is_sub;
	psid_pkg::psid_mode_t sat_mode;

	assign is_sub = (op_code == psid_pkg::PSID_OP_SUB);
	assign sat_mode = op_mode;

	// One cell per lane; no carry path joins them
	genvar g;
	generate
		for (g = 0; g < NB; g++) begin : g_byte
			psid_lane #(
				.W(BW),
				.SMIN(psid_pkg::PSID_SB_MIN),
				.SMAX(psid_pkg::PSID_SB_MAX),
				.UMIN(psid_pkg::PSID_UB_MIN),
				.UMAX(psid_pkg::PSID_UB_MAX)
			) u_lane (
				.a(dst_val[g*BW +: BW]),
				.b(src_val[g*BW +: BW]),
				.sub(is_sub),
				.mode(sat_mode),
				.y(sum_b[g*BW +: BW])
			);
		end
		for (g = 0; g < NW; g++) begin : g_word
			psid_lane #(
				.W(WW),
				.SMIN(psid_pkg::PSID_SW_MIN),
				.SMAX(psid_pkg::PSID_SW_MAX),
				.UMIN(psid_pkg::PSID_UW_MIN),
				.UMAX(psid_pkg::PSID_UW_MAX)
			) u_lane (
				.a(dst_val[g*WW +: WW]),
				.b(src_val[g*WW +: WW]),
				.sub(is_sub),
				.mode(sat_mode),
				.y(sum_w[g*WW +: WW])
			);
		end
		for (g = 0; g < ND; g++) begin : g_dword
			// Doubleword lanes only wrap
			psid_lane #(
				.W(DW),
				.SMIN(psid_pkg::PSID_SD_MIN),
				.SMAX(psid_pkg::PSID_SD_MAX),
				.UMIN(psid_pkg::PSID_UD_MIN),
				.UMAX(psid_pkg::PSID_UD_MAX)
			) u_lane (
				.a(dst_val[g*DW +: DW]),
				.b(src_val[g*DW +: DW]),
				.sub(is_sub),
				.mode(psid_pkg::PSID_MODE_WRAP),
				.y(sum_d[g*DW +: DW])
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// Unpack: interleave low or high halves of both operands
	// ------------------------------------------------------------
	function automatic logic [63:0] psid_unpack(input logic [63:0] d, input logic [63:0] s,
		input logic hi, input psid_pkg::psid_size_t sz);
		logic [31:0] dh;
		logic [31:0] sh;
		logic [63:0] r;
		dh = hi ? d[63:32] : d[31:0];
		sh = hi ? s[63:32] : s[31:0];
		r = '0;
		case (sz)
			psid_pkg::PSID_SZ_B: begin
				for (int k = 0; k < NB / 2; k++) begin
					r[2*k*BW +: BW] = dh[k*BW +: BW];
					r[(2*k+1)*BW +: BW] = sh[k*BW +: BW];
				end
			end
			psid_pkg::PSID_SZ_W: begin
				for (int k = 0; k < NW / 2; k++) begin
					r[2*k*WW +: WW] = dh[k*WW +: WW];
					r[(2*k+1)*WW +: WW] = sh[k*WW +: WW];
				end
			end
			default: begin
				r = {sh, dh};
			end
		endcase
		return r;
	endfunction

	// ------------------------------------------------------------
	// Result select
	// ------------------------------------------------------------
	always_comb begin
		wr_en = op_valid;
		wr_data = dst_val;
		case (op_code)
			psid_pkg::PSID_OP_ADD, psid_pkg::PSID_OP_SUB: begin
				case (op_size)
					psid_pkg::PSID_SZ_B: wr_data = sum_b;
					psid_pkg::PSID_SZ_W: wr_data = sum_w;
					default: wr_data = sum_d;
				endcase
			end
			psid_pkg::PSID_OP_AND: wr_data = dst_val & src_val;
			psid_pkg::PSID_OP_ANDN: wr_data = ~dst_val & src_val;
			psid_pkg::PSID_OP_OR: wr_data = dst_val | src_val;
			psid_pkg::PSID_OP_XOR: wr_data = dst_val ^ src_val;
			psid_pkg::PSID_OP_MOVQ_RR: wr_data = src_val;
			psid_pkg::PSID_OP_LOAD64: wr_data = mem_rdata;
			psid_pkg::PSID_OP_LOAD32: wr_data = {{HW{1'b0}}, mem_rdata[HW-1:0]};
			psid_pkg::PSID_OP_FROM_GP: wr_data = {{HW{1'b0}}, gp_wdata};
			psid_pkg::PSID_OP_UNPK_LO: wr_data = psid_unpack(dst_val, src_val, 1'b0, op_size);
			psid_pkg::PSID_OP_UNPK_HI: wr_data = psid_unpack(dst_val, src_val, 1'b1, op_size);
			default: wr_en = 1'b0;
		endcase
	end

	// ------------------------------------------------------------
	// Register file with floating-point alias port
	// ------------------------------------------------------------
	// A datapath write beats a floating-point write to the same slot
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < psid_pkg::PSID_NREGS; i++) begin
				regs_r[i] <= '0;
			end
		end else begin
			for (int i = 0; i < psid_pkg::PSID_NREGS; i++) begin
				if (wr_en && op_dst == 3'(i)) begin
					regs_r[i] <= wr_data;
				end else if (fpu_wr_en && fpu_wr_idx == 3'(i)) begin
					regs_r[i] <= fpu_wr_data;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			fpu_rd_data_r <= '0;
		end else begin
			fpu_rd_data_r <= regs_r[fpu_rd_idx];
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			res_valid_r <= 1'b0;
			res_data_r <= '0;
		end else begin
			res_valid_r <= wr_en;
			res_data_r <= wr_data;
		end
	end

	// ------------------------------------------------------------
	// Store and general-purpose read ports
	// ------------------------------------------------------------
	// Byte k of mem_wdata_r belongs at the base address plus k
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			mem_wvalid_r <= 1'b0;
			mem_wdata_r <= '0;
			mem_wbe_r <= '0;
		end else begin
			mem_wvalid_r <= op_valid && (op_code == psid_pkg::PSID_OP_STORE64 ||
				op_code == psid_pkg::PSID_OP_STORE32);
			if (op_valid && op_code == psid_pkg::PSID_OP_STORE64) begin
				mem_wdata_r <= src_val;
				mem_wbe_r <= psid_pkg::PSID_BE_FULL;
			end else if (op_valid && op_code == psid_pkg::PSID_OP_STORE32) begin
				mem_wdata_r <= {{HW{1'b0}}, src_val[HW-1:0]};
				mem_wbe_r <= psid_pkg::PSID_BE_LOW;
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			gp_rvalid_r <= 1'b0;
			gp_rdata_r <= '0;
		end else begin
			gp_rvalid_r <= op_valid && op_code == psid_pkg::PSID_OP_TO_GP;
			if (op_valid && op_code == psid_pkg::PSID_OP_TO_GP) begin
				gp_rdata_r <= src_val[HW-1:0];
			end
		end
	end

	// Overflow is silent: these stay low so the core never sees a flag or trap
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			condition_flag_register_we_r <= 1'b0;
			exception_r <= 1'b0;
		end else begin
			condition_flag_register_we_r <= 1'b0;
			exception_r <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	logic is_wadd_ss;
	logic is_badd_wrap;
	logic is_bsub_us;
	assign is_wadd_ss = op_valid && op_code == psid_pkg::PSID_OP_ADD &&
		op_size == psid_pkg::PSID_SZ_W && op_mode == psid_pkg::PSID_MODE_SSAT;
	assign is_badd_wrap = op_valid && op_code == psid_pkg::PSID_OP_ADD &&
		op_size == psid_pkg::PSID_SZ_B && op_mode == psid_pkg::PSID_MODE_WRAP;
	assign is_bsub_us = op_valid && op_code == psid_pkg::PSID_OP_SUB &&
		op_size == psid_pkg::PSID_SZ_B && op_mode == psid_pkg::PSID_MODE_USAT;

	sequence s_fpu_write;
		fpu_wr_en && !(wr_en && op_dst == fpu_wr_idx);
	endsequence
	sequence s_read_back;
		fpu_rd_data_r == $past(fpu_wr_data, 2);
	endsequence
	logic [15:0] w3_sum;
	assign w3_sum = dst_val[63:48] + src_val[63:48];

	a_alias_visible: assert property (
		s_fpu_write ##1 (fpu_rd_idx == $past(fpu_wr_idx)) |-> ##1 s_read_back)
		else $error("alias write not seen");
	a_load_format: assert property (
		op_valid && op_code == psid_pkg::PSID_OP_LOAD64 |=>
		regs_r[$past(op_dst)] == $past(mem_rdata)) else $error("load64 reformatted");
	a_load32_zero: assert property (
		op_valid && op_code == psid_pkg::PSID_OP_LOAD32 |=>
		regs_r[$past(op_dst)][63:32] == '0) else $error("load32 upper not zero");
	a_movq_whole: assert property (
		op_valid && op_code == psid_pkg::PSID_OP_MOVQ_RR |=>
		res_valid_r && res_data_r == $past(src_val)) else $error("movq altered data");
	a_word_ssat_hi: assert property (is_wadd_ss && !dst_val[15] && !src_val[15] &&
		dst_val[15:0] + src_val[15:0] > {1'b0, psid_pkg::PSID_SW_MAX} |=>
		regs_r[$past(op_dst)][15:0] == psid_pkg::PSID_SW_MAX)
		else $error("word signed saturation high");
	a_word_ssat_lane3: assert property (is_wadd_ss &&
		dst_val[63] && src_val[63] && !w3_sum[15] |=>
		regs_r[$past(op_dst)][63:48] == psid_pkg::PSID_SW_MIN)
		else $error("word signed saturation low");
	a_byte_usat_lo: assert property (is_bsub_us && dst_val[7:0] < src_val[7:0] |=>
		regs_r[$past(op_dst)][7:0] == psid_pkg::PSID_UB_MIN)
		else $error("byte unsigned saturation low");
	a_byte_wrap_lane: assert property (is_badd_wrap |=>
		regs_r[$past(op_dst)][15:8] == 8'($past(dst_val[15:8]) + $past(src_val[15:8])))
		else $error("byte wrap lane wrong");
	a_store_le: assert property (op_valid && op_code == psid_pkg::PSID_OP_STORE32 |=>
		mem_wvalid_r && mem_wbe_r == psid_pkg::PSID_BE_LOW &&
		mem_wdata_r[7:0] == $past(src_val[7:0])) else $error("store32 layout wrong");
	a_flags_quiet: assert property (!condition_flag_register_we_r && !exception_r)
		else $error("flag or exception raised");
endmodule

/* File: psid_mem_model.sv */
/*
 * Behavioural memory standing in for the core load/store logic: sixteen bytes
 * that feed load data and take store data through the byte enables.
 * Assumes one clock shared with the datapath and addresses set by the bench.
 */
`timescale 1ns/1ps

module psid_mem_model (
	input wire logic clk,
	input wire logic [3:0] ld_addr,
	input wire logic [3:0] st_addr,
	input wire logic mem_wvalid_r,
	input wire logic [63:0] mem_wdata_r,
	input wire logic [7:0] mem_wbe_r,
	output logic [63:0] mem_rdata
);
	logic [7:0] bytes [16];

	// --------------------------------
	// Storage
	// --------------------------------
	initial begin
		for (int i = 0; i < 16; i++) begin
			bytes[i] = 8'h10 + 8'(i);
		end
	end

	// Lowest address lands in the least significant byte
	always_comb begin
		for (int k = 0; k < 8; k++) begin
			mem_rdata[8*k +: 8] = bytes[4'(ld_addr + 4'(k))];
		end
	end

	always @(posedge clk) begin
		if (mem_wvalid_r) begin
			for (int k = 0; k < 8; k++) begin
				if (mem_wbe_r[k]) begin
					bytes[4'(st_addr + 4'(k))] <= mem_wdata_r[8*k +: 8];
				end
			end
		end
	end
endmodule

/* File: packed_simd_integer_datapath_bench.sv */
/*
 * Self-checking bench for the packed SIMD integer datapath: moves, memory
 * layout, register aliasing and lane arithmetic in every size and mode.
 * Assumes the datapath and the memory model are compiled beforehand.
 */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin err_count++; \
	$display("FAIL %s expected %h seen %h", nm, e, g); end end

module packed_simd_integer_datapath_bench;
	localparam logic [63:0] VA = 64'h7FFF_8000_FF01_807F;
	localparam logic [63:0] VB = 64'h0001_FFFF_0102_FF81;
	logic clk, resetn, op_valid, fpu_wr_en, res_valid_r, mem_wvalid_r, gp_rvalid_r;
	logic flag_we, exc;
	psid_pkg::psid_op_t op_code;
	psid_pkg::psid_size_t op_size;
	psid_pkg::psid_mode_t op_mode;
	logic [2:0] op_dst, op_src, fpu_wr_idx, fpu_rd_idx;
	logic [63:0] mem_rdata, fpu_wr_data, res_data_r, mem_wdata_r, fpu_rd_data_r;
	logic [31:0] gp_wdata, gp_rdata_r;
	logic [7:0] mem_wbe_r;
	logic [3:0] ld_addr, st_addr;
	int err_count, checks;

	psid_datapath i_psid_datapath (.clk(clk), .resetn(resetn), .op_valid(op_valid),
		.op_code(op_code), .op_size(op_size), .op_mode(op_mode), .op_dst(op_dst),
		.op_src(op_src), .mem_rdata(mem_rdata), .gp_wdata(gp_wdata),
		.fpu_wr_en(fpu_wr_en), .fpu_wr_idx(fpu_wr_idx), .fpu_wr_data(fpu_wr_data),
		.fpu_rd_idx(fpu_rd_idx), .res_valid_r(res_valid_r), .res_data_r(res_data_r),
		.mem_wvalid_r(mem_wvalid_r), .mem_wdata_r(mem_wdata_r), .mem_wbe_r(mem_wbe_r),
		.gp_rvalid_r(gp_rvalid_r), .gp_rdata_r(gp_rdata_r), .fpu_rd_data_r(fpu_rd_data_r),
		.condition_flag_register_we_r(flag_we), .exception_r(exc));

	psid_mem_model i_psid_mem_model (.clk(clk), .ld_addr(ld_addr), .st_addr(st_addr),
		.mem_wvalid_r(mem_wvalid_r), .mem_wdata_r(mem_wdata_r), .mem_wbe_r(mem_wbe_r),
		.mem_rdata(mem_rdata));

	// --------------------------------
	// Drivers
	// --------------------------------
	task automatic run_op(psid_pkg::psid_op_t c, psid_pkg::psid_size_t z,
		psid_pkg::psid_mode_t m, logic [2:0] d, logic [2:0] s);
		@(posedge clk);
		op_valid <= 1'b1;
		op_code <= c;
		op_size <= z;
		op_mode <= m;
		op_dst <= d;
		op_src <= s;
		@(posedge clk);
		op_valid <= 1'b0;
		@(negedge clk);
	endtask

	task automatic fpu_put(logic [2:0] i, logic [63:0] d);
		@(posedge clk);
		fpu_wr_en <= 1'b1;
		fpu_wr_idx <= i;
		fpu_wr_data <= d;
		@(posedge clk);
		fpu_wr_en <= 1'b0;
	endtask

	task automatic fpu_get(logic [2:0] i, output logic [63:0] d);
		@(posedge clk);
		fpu_rd_idx <= i;
		@(posedge clk);
		@(negedge clk);
		d = fpu_rd_data_r;
	endtask

	// Reference lane arithmetic; wide enough that no true result is lost
	function automatic logic [63:0] exp_arith(logic [63:0] a, logic [63:0] b, bit s,
		int w, int md);
		longint ua, ub, sa, sb, r, h;
		logic [63:0] m, y;
		m = (64'h1 << w) - 64'h1;
		h = longint'(1) << (w - 1);
		y = '0;
		for (int i = 0; i < 64 / w; i++) begin
			ua = longint'((a >> (i * w)) & m);
			ub = longint'((b >> (i * w)) & m);
			sa = (ua >= h) ? ua - 2 * h : ua;
			sb = (ub >= h) ? ub - 2 * h : ub;
			r = (md == 1) ? (s ? sa - sb : sa + sb) : (s ? ua - ub : ua + ub);
			if (md == 1) begin
				r = (r > h - 1) ? h - 1 : ((r < -h) ? -h : r);
			end else if (md == 2) begin
				r = (r > longint'(m)) ? longint'(m) : ((r < 0) ? 0 : r);
			end
			y |= (64'(r) & m) << (i * w);
		end
		return y;
	endfunction

	// --------------------------------
	// Scenarios
	// --------------------------------
	task automatic t_memory;
		run_op(psid_pkg::PSID_OP_LOAD64, psid_pkg::PSID_SZ_B, psid_pkg::PSID_MODE_WRAP, 3'h1, 3'h0);
		`CHK("load64", 64'h1716_1514_1312_1110, res_data_r)
		run_op(psid_pkg::PSID_OP_STORE64, psid_pkg::PSID_SZ_B, psid_pkg::PSID_MODE_WRAP, 3'h0, 3'h1);
		`CHK("st64_valid", 1'b1, mem_wvalid_r)
		`CHK("st64_data", 64'h1716_1514_1312_1110, mem_wdata_r)
		`CHK("st64_be", 8'hFF, mem_wbe_r)
		`CHK("st64_nowrite", 1'b0, res_valid_r)
		run_op(psid_pkg::PSID_OP_FROM_GP, psid_pkg::PSID_SZ_B, psid_pkg::PSID_MODE_WRAP, 3'h3, 3'h0);
		`CHK("from_gp", 64'h0000_0000_A5A5_5A5A, res_data_r)
		run_op(psid_pkg::PSID_OP_STORE32, psid_pkg::PSID_SZ_B, psid_pkg::PSID_MODE_WRAP, 3'h0, 3'h3);
		`CHK("st32_be", 8'h0F, mem_wbe_r)
		`CHK("st32_valid", 1'b1, mem_wvalid_r)
		`CHK("st32_data", 64'h0000_0000_A5A5_5A5A, mem_wdata_r)
		run_op(psid_pkg::PSID_OP_TO_GP, psid_pkg::PSID_SZ_B, psid_pkg::PSID_MODE_WRAP, 3'h0, 3'h1);
		`CHK("to_gp", 32'h1312_1110, gp_rdata_r)
		`CHK("to_gp_valid", 1'b1, gp_rvalid_r)
		@(posedge clk);
		ld_addr <= 4'h8;
		run_op(psid_pkg::PSID_OP_LOAD64, psid_pkg::PSID_SZ_B, psid_pkg::PSID_MODE_WRAP, 3'h4, 3'h0);
		`CHK("reload64", 64'h1716_1514_A5A5_5A5A, res_data_r)
		run_op(psid_pkg::PSID_OP_LOAD32, psid_pkg::PSID_SZ_B, psid_pkg::PSID_MODE_WRAP, 3'h2, 3'h0);
		`CHK("load32", 64'h0000_0000_A5A5_5A5A, res_data_r)
	endtask

	task automatic t_alias;
		logic [63:0] v;
		fpu_put(3'h7, 64'hDEAD_BEEF_0123_4567);
		run_op(psid_pkg::PSID_OP_MOVQ_RR, psid_pkg::PSID_SZ_B, psid_pkg::PSID_MODE_WRAP, 3'h0, 3'h7);
		`CHK("move", 64'hDEAD_BEEF_0123_4567, res_data_r)
		fpu_get(3'h0, v);
		`CHK("fpu_view0", 64'hDEAD_BEEF_0123_4567, v)
		fpu_get(3'h1, v);
		`CHK("fpu_view1", 64'h1716_1514_1312_1110, v)
	endtask

	task automatic t_lanes;
		psid_pkg::psid_op_t lop[4];
		logic [63:0] lexp[4];
		logic [63:0] lx;
		lop = '{psid_pkg::PSID_OP_AND, psid_pkg::PSID_OP_ANDN, psid_pkg::PSID_OP_OR,
			psid_pkg::PSID_OP_XOR};
		lexp = '{VA & VB, ~VA & VB, VA | VB, VA ^ VB};
		for (int z = 0; z < 3; z++) begin
			for (int m = 0; m < 3; m++) begin
				for (int s = 0; s < 2; s++) begin
					fpu_put(3'h1, VA);
					fpu_put(3'h2, VB);
					run_op(s ? psid_pkg::PSID_OP_SUB : psid_pkg::PSID_OP_ADD,
						psid_pkg::psid_size_t'(z), psid_pkg::psid_mode_t'(m), 3'h1, 3'h2);
					`CHK("lane_valid", 1'b1, res_valid_r)
					lx = exp_arith(VA, VB, s[0], 8 << z, (z == 2) ? 0 : m);
					`CHK("sum", lx, res_data_r)
					`CHK("no_flags", 2'b00, {flag_we, exc})
				end
			end
		end
		for (int k = 0; k < 4; k++) begin
			fpu_put(3'h1, VA);
			run_op(lop[k], psid_pkg::PSID_SZ_B, psid_pkg::PSID_MODE_WRAP, 3'h1, 3'h2);
			`CHK("logic", lexp[k], res_data_r)
		end
	endtask

	task automatic t_unpack;
		psid_pkg::psid_op_t uop[3];
		psid_pkg::psid_size_t usz[3];
		logic [63:0] uexp[3];
		uop = '{psid_pkg::PSID_OP_UNPK_LO, psid_pkg::PSID_OP_UNPK_HI,
			psid_pkg::PSID_OP_UNPK_LO};
		usz = '{psid_pkg::PSID_SZ_B, psid_pkg::PSID_SZ_W, psid_pkg::PSID_SZ_D};
		uexp = '{64'h01FF_0201_FF80_817F, 64'h0001_7FFF_FFFF_8000,
			64'h0102_FF81_FF01_807F};
		for (int k = 0; k < 3; k++) begin
			fpu_put(3'h1, VA);
			fpu_put(3'h2, VB);
			run_op(uop[k], usz[k], psid_pkg::PSID_MODE_WRAP, 3'h1, 3'h2);
			`CHK("unpack", uexp[k], res_data_r)
		end
	endtask

	// Word 0 overflows upward, word 3 downward, words 1 and 2 stay in range
	task automatic t_sat_edges;
		fpu_put(3'h1, 64'h8000_1234_5678_7000);
		fpu_put(3'h2, 64'h8001_0000_0000_1000);
		run_op(psid_pkg::PSID_OP_ADD, psid_pkg::PSID_SZ_W, psid_pkg::PSID_MODE_SSAT, 3'h1, 3'h2);
		`CHK("word_ssat", 64'h8000_1234_5678_7FFF, res_data_r)
		`CHK("sat_flags", 2'b00, {flag_we, exc})
	endtask

	task summarize;
		$display("checks %0d err_count %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// --------------------------------
	// Run control
	// --------------------------------
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	initial begin
		repeat (5000) @(posedge clk);
		err_count++;
		summarize();
	end

	initial begin
		{resetn, op_valid, fpu_wr_en} = 3'b000;
		op_code = psid_pkg::PSID_OP_NOP;
		op_size = psid_pkg::PSID_SZ_B;
		op_mode = psid_pkg::PSID_MODE_WRAP;
		{op_dst, op_src, fpu_wr_idx, fpu_rd_idx} = 12'h000;
		fpu_wr_data = 64'h0;
		gp_wdata = 32'hA5A5_5A5A;
		ld_addr = 4'h0;
		st_addr = 4'h8;
		err_count = 0;
		checks = 0;
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		@(negedge clk);
		`CHK("reset_res", 64'h0, res_data_r)
		t_memory();
		t_alias();
		t_lanes();
		t_unpack();
		t_sat_edges();
		summarize();
	end
endmodule
